// *** bench/host_uart_model.sv ***
`timescale 1ns/1ps
module host_uart_model (
    input wire logic clk,                // system clock
    input wire logic tx_pin,             // device serial out
    input wire logic rts_n,              // device lets host send, active low
    input wire logic hold,               // host withholds permission
    input wire logic sleep,              // host wants device in hibernate
    input wire logic [15:0] bit_cycles,  // clock cycles per bit
    output logic rx_pin,                 // serial data to device
    output logic cts_n_pin,              // host lets device send, active low
    output logic hibernate_request_n     // hibernate request, active low
);
    logic [8:0] got_q[$];
    logic [8:0] shift;
    int stall_count = 0;

    assign cts_n_pin = hold;
    assign hibernate_request_n = ~sleep;
    initial rx_pin = 1'b1;

    // one 8N1 character, lsb first; a bad stop is low for three quarters of a bit
    task automatic send(input logic [7:0] b, input logic stop_ok, input logic honour);
        int n;
        n = 0;
        while (honour && rts_n !== 1'b0 && n < 20000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 20000) stall_count++;
        @(negedge clk);
        rx_pin = 1'b0;
        repeat (bit_cycles) @(negedge clk);
        for (int i = 0; i < 8; i++) begin
            rx_pin = b[i];
            repeat (bit_cycles) @(negedge clk);
        end
        rx_pin = stop_ok;
        repeat (stop_ok ? bit_cycles : bit_cycles * 3 / 4) @(negedge clk);
        rx_pin = 1'b1;
        repeat (bit_cycles) @(negedge clk);
    endtask

    // catch every character the device sends, sampling at bit centres
    initial begin
        forever begin
            @(negedge tx_pin);
            repeat (bit_cycles / 2) @(posedge clk);
            if (tx_pin === 1'b0) begin
                for (int i = 0; i < 8; i++) begin
                    repeat (bit_cycles) @(posedge clk);
                    shift[i] = tx_pin;
                end
                repeat (bit_cycles) @(posedge clk);
                shift[8] = tx_pin;
                got_q.push_back(shift);
            end
        end
    end
endmodule

// *** bench/test_host_uart_link.sv ***
`timescale 1ns/1ps
module test_host_uart_link;
    logic clk, rst, ce, rate_load, attention_req, tx_valid, rx_ready, hold, sleep;
    logic [1:0] topology;
    logic [15:0] rate_div, bit_cyc, divisor;
    logic [7:0] tx_data, rx_data;
    logic rx_pin, cts_n_pin, hibernate_request_n, tx_pin, rts_n, attention_to_host, hibernate, tx_ready;
    logic rx_valid, frame_err, overrun;
    int errors, cmp_count, fe_seen, ov_seen;

    initial clk = 1'b0;
    always #4 clk = ~clk;

    host_uart_link host_uart_link_inst (.clk(clk), .rst(rst), .ce(ce), .topology(topology),
        .rate_load(rate_load), .rate_div(rate_div), .rx_pin(rx_pin), .cts_n_pin(cts_n_pin),
        .hibernate_request_n(hibernate_request_n), .attention_req(attention_req), .tx_data(tx_data),
        .tx_valid(tx_valid), .rx_ready(rx_ready), .tx_pin(tx_pin), .rts_n(rts_n),
        .attention_to_host(attention_to_host), .hibernate(hibernate), .tx_ready(tx_ready),
        .rx_data(rx_data), .rx_valid(rx_valid), .frame_err(frame_err), .overrun(overrun), .divisor(divisor));

    host_uart_model host_uart_model_inst (.clk(clk), .tx_pin(tx_pin), .rts_n(rts_n), .hold(hold),
        .sleep(sleep), .bit_cycles(bit_cyc), .rx_pin(rx_pin), .cts_n_pin(cts_n_pin),
        .hibernate_request_n(hibernate_request_n));

    always @(negedge clk) begin
        if (frame_err === 1'b1) fe_seen++;
        if (overrun === 1'b1) ov_seen++;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic test_done();
        if (errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge clk);
    endtask

    // offer one byte and hold it until the design takes it
    task automatic put_byte(input logic [7:0] b);
        int n;
        n = 0;
        @(negedge clk);
        tx_data = b;
        tx_valid = 1'b1;
        while (tx_ready !== 1'b1 && n < 20000) begin
            @(negedge clk);
            n++;
        end
        chk("tx_ready", 16'h0001, tx_ready);
        // the rising edge in between takes the byte
        @(negedge clk);
        tx_valid = 1'b0;
    endtask

    task automatic expect_host(input logic [7:0] b);
        int n;
        n = 0;
        while (host_uart_model_inst.got_q.size() == 0 && n < 20000) begin
            @(negedge clk);
            n++;
        end
        if (host_uart_model_inst.got_q.size() > 0) begin
            chk("host byte", {7'h00, 1'b1, b}, {7'h00, host_uart_model_inst.got_q.pop_front()});
        end else begin
            chk("host byte", {7'h00, 1'b1, b}, 16'hDEAD);
        end
    endtask

    task automatic consume();
        @(negedge clk);
        rx_ready = 1'b1;
        @(negedge clk);
        rx_ready = 1'b0;
    endtask

    task automatic set_rate(input logic [15:0] d, input logic [15:0] eff);
        @(negedge clk);
        rate_div = d;
        rate_load = 1'b1;
        @(negedge clk);
        rate_load = 1'b0;
        chk("divisor", eff, divisor);
        bit_cyc = eff * 16;
    endtask

    initial begin
        #600000;
        errors++;
        test_done();
    end

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        topology = 2'h0;
        rate_load = 1'b0;
        rate_div = 16'h0044;
        attention_req = 1'b0;
        tx_valid = 1'b0;
        tx_data = 8'h00;
        rx_ready = 1'b0;
        hold = 1'b0;
        sleep = 1'b0;
        bit_cyc = uart_link_pkg::DIV_DEFAULT * 16;
        errors = 0;
        cmp_count = 0;
        fe_seen = 0;
        ov_seen = 0;
        cycles(16);
        chk("tx_pin", 16'h0001, tx_pin);
        chk("rts_n", 16'h0001, rts_n);
        chk("attention", 16'h0000, attention_to_host);
        chk("tx_ready", 16'h0000, tx_ready);
        chk("rx_valid", 16'h0000, rx_valid);
        chk("divisor", uart_link_pkg::DIV_DEFAULT, divisor);
        rst = 1'b0;
        host_uart_model_inst.send(8'hA5, 1'b1, 1'b1);
        chk("rx_valid", 16'h0001, rx_valid);
        chk("rx_data", 16'h00A5, rx_data);
        chk("rts_n full", 16'h0001, rts_n);
        consume();
        cycles(2);
        chk("rx_valid", 16'h0000, rx_valid);
        chk("rts_n free", 16'h0000, rts_n);
        set_rate(16'h0001, uart_link_pkg::DIV_MIN);
        put_byte(8'h34);
        put_byte(8'h12);
        expect_host(8'h34);
        expect_host(8'h12);
        hold = 1'b1;
        // let the character in flight finish so only the withheld permission keeps ready low
        cycles(64);
        chk("tx_ready held", 16'h0000, tx_ready);
        hold = 1'b0;
        put_byte(8'h5A);
        expect_host(8'h5A);
        topology = 2'h2;
        hold = 1'b1;
        cycles(64);
        chk("tx_ready three", 16'h0001, tx_ready);
        put_byte(8'hC3);
        expect_host(8'hC3);
        hold = 1'b0;
        topology = 2'h0;
        host_uart_model_inst.send(8'h0F, 1'b0, 1'b1);
        cycles(4);
        chk("frame_err", 16'h0001, 16'(fe_seen));
        chk("rx_valid", 16'h0000, rx_valid);
        host_uart_model_inst.send(8'h11, 1'b1, 1'b1);
        host_uart_model_inst.send(8'h22, 1'b1, 1'b0);
        cycles(2);
        chk("overrun", 16'h0001, 16'(ov_seen));
        chk("rx_data", 16'h0022, rx_data);
        consume();
        attention_req = 1'b1;
        cycles(2);
        chk("attention", 16'h0001, attention_to_host);
        ce = 1'b0;
        attention_req = 1'b0;
        cycles(4);
        chk("attention frozen", 16'h0001, attention_to_host);
        attention_req = 1'b1;
        ce = 1'b1;
        topology = 2'h1;
        cycles(2);
        chk("attention four", 16'h0000, attention_to_host);
        topology = 2'h0;
        sleep = 1'b1;
        cycles(5);
        chk("hibernate", 16'h0001, hibernate);
        chk("tx_ready", 16'h0000, tx_ready);
        chk("rts_n", 16'h0001, rts_n);
        chk("attention", 16'h0000, attention_to_host);
        sleep = 1'b0;
        cycles(5);
        chk("hibernate", 16'h0000, hibernate);
        chk("attention", 16'h0001, attention_to_host);
        chk("host stalls", 16'h0000, 16'(host_uart_model_inst.stall_count));
        test_done();
    end
endmodule

// *** hw/host_uart_link.sv ***
`timescale 1ns/1ps
module host_uart_link (
    input wire logic clk,                 // system clock, 125 MHz
    input wire logic rst,                 // synchronous reset, active high
    input wire logic ce,                  // clock enable, freezes all state
    input wire logic [1:0] topology,      // wiring: 0 five, 1 four, 2 three
    input wire logic rate_load,           // pulse: apply rate_div after rate command
    input wire logic [15:0] rate_div,     // cycles per 1/16 bit for new rate
    input wire logic rx_pin,              // serial data from host
    input wire logic cts_n_pin,           // host permission to send, active low
    input wire logic hibernate_request_n, // host hibernate request, active low
    input wire logic attention_req,       // device logic wants a transfer
    input wire logic [7:0] tx_data,       // byte to send
    input wire logic tx_valid,            // tx_data valid
    input wire logic rx_ready,            // user takes rx_data
    output logic tx_pin,                  // serial data to host
    output logic rts_n,                   // permission for host to send, active low
    output logic attention_to_host,       // attention line to host
    output logic hibernate,               // device in hibernate
    output logic tx_ready,                // tx_data accepted when valid
    output logic [7:0] rx_data,           // received byte
    output logic rx_valid,                // rx_data holds an unread byte
    output logic frame_err,               // pulse: stop bit missing
    output logic overrun,                 // pulse: byte lost, holding full
    output logic [15:0] divisor           // divisor in use
);
    logic tick;
    rate_tick u_rate_tick (.clk(clk), .rst(rst), .ce(ce), .rate_load(rate_load), .rate_div(rate_div),
        .divisor(divisor), .tick(tick));
    // pin synchronisers
    logic rx_m_q, rx_s_q, cts_m_q, cts_s_q, hib_m_q, hib_s_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_m_q <= 1'b1;
            rx_s_q <= 1'b1;
            cts_m_q <= 1'b1;
            cts_s_q <= 1'b1;
            hib_m_q <= 1'b1;
            hib_s_q <= 1'b1;
        end else if (ce) begin
            rx_m_q <= rx_pin;
            rx_s_q <= rx_m_q;
            cts_m_q <= cts_n_pin;
            cts_s_q <= cts_m_q;
            hib_m_q <= hibernate_request_n;
            hib_s_q <= hib_m_q;
        end
    end
    logic three_wire, five_wire, hib_d;
    assign three_wire = (topology == uart_link_pkg::TOPO_THREE);
    assign five_wire = (topology != uart_link_pkg::TOPO_FOUR) && !three_wire;
    assign hib_d = !hib_s_q;
    // receiver
    uart_link_pkg::rx_state_e rx_st_q, rx_st_d;
    logic [3:0] rx_cnt_q, rx_cnt_d;
    logic [2:0] rx_bit_q, rx_bit_d;
    logic [7:0] rx_sh_q, rx_sh_d, rx_data_q, rx_data_d;
    logic rx_valid_q, rx_valid_d, frame_err_q, frame_err_d, overrun_q, overrun_d, rts_n_q, rts_n_d;
    always_comb begin
        rx_st_d = rx_st_q;
        rx_cnt_d = rx_cnt_q;
        rx_bit_d = rx_bit_q;
        rx_sh_d = rx_sh_q;
        rx_data_d = rx_data_q;
        rx_valid_d = rx_valid_q && !rx_ready;
        frame_err_d = 1'b0;
        overrun_d = 1'b0;
        if (hib_d) begin
            rx_st_d = uart_link_pkg::RX_IDLE;
        end else if (tick) begin
            unique case (rx_st_q)
                uart_link_pkg::RX_IDLE: begin
                    if (!rx_s_q) begin
                        rx_st_d = uart_link_pkg::RX_START;
                        rx_cnt_d = 4'h0;
                    end
                end
                uart_link_pkg::RX_START: begin
                    if (rx_cnt_q == uart_link_pkg::TICK_MID) begin
                        // start bit re-checked at its centre; glitches drop back
                        rx_st_d = rx_s_q ? uart_link_pkg::RX_IDLE : uart_link_pkg::RX_DATA;
                        rx_cnt_d = 4'h0;
                        rx_bit_d = 3'h0;
                    end else begin
                        rx_cnt_d = rx_cnt_q + 4'h1;
                    end
                end
                uart_link_pkg::RX_DATA: begin
                    if (rx_cnt_q == uart_link_pkg::TICK_LAST) begin
                        rx_cnt_d = 4'h0;
                        rx_sh_d = {rx_s_q, rx_sh_q[7:1]};
                        rx_bit_d = rx_bit_q + 3'h1;
                        if (rx_bit_q == uart_link_pkg::LAST_BIT) begin
                            rx_st_d = uart_link_pkg::RX_STOP;
                        end
                    end else begin
                        rx_cnt_d = rx_cnt_q + 4'h1;
                    end
                end
                uart_link_pkg::RX_STOP: begin
                    if (rx_cnt_q == uart_link_pkg::TICK_LAST) begin
                        rx_st_d = uart_link_pkg::RX_IDLE;
                        if (rx_s_q) begin
                            // new byte wins over a same-cycle read
                            overrun_d = rx_valid_q && !rx_ready;
                            rx_data_d = rx_sh_q;
                            rx_valid_d = 1'b1;
                        end else begin
                            frame_err_d = 1'b1;
                        end
                    end else begin
                        rx_cnt_d = rx_cnt_q + 4'h1;
                    end
                end
            endcase
        end
        // holding register full or hibernating: hold the host off
        rts_n_d = rx_valid_d || hib_d;
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_st_q <= uart_link_pkg::RX_IDLE;
            rx_cnt_q <= 4'h0;
            rx_bit_q <= 3'h0;
            rx_sh_q <= uart_link_pkg::BYTE_RESET;
            rx_data_q <= uart_link_pkg::BYTE_RESET;
            rx_valid_q <= 1'b0;
            frame_err_q <= 1'b0;
            overrun_q <= 1'b0;
            rts_n_q <= 1'b1;
        end else if (ce) begin
            rx_st_q <= rx_st_d;
            rx_cnt_q <= rx_cnt_d;
            rx_bit_q <= rx_bit_d;
            rx_sh_q <= rx_sh_d;
            rx_data_q <= rx_data_d;
            rx_valid_q <= rx_valid_d;
            frame_err_q <= frame_err_d;
            overrun_q <= overrun_d;
            rts_n_q <= rts_n_d;
        end
    end
    // transmitter
    uart_link_pkg::tx_state_e tx_st_q, tx_st_d;
    logic [3:0] tx_cnt_q, tx_cnt_d;
    logic [2:0] tx_bit_q, tx_bit_d;
    logic [7:0] tx_sh_q, tx_sh_d;
    logic tx_pin_q, tx_pin_d, tx_ready_q, tx_ready_d;
    always_comb begin
        tx_st_d = tx_st_q;
        tx_cnt_d = tx_cnt_q;
        tx_bit_d = tx_bit_q;
        tx_sh_d = tx_sh_q;
        tx_pin_d = tx_pin_q;
        if (hib_d) begin
            tx_st_d = uart_link_pkg::TX_IDLE;
            tx_pin_d = 1'b1;
        end else if (tx_st_q == uart_link_pkg::TX_IDLE) begin
            tx_pin_d = 1'b1;
            // bytes leave in the order presented, so multi-byte words keep their order
            if (tx_valid && tx_ready_q) begin
                tx_st_d = uart_link_pkg::TX_START;
                tx_sh_d = tx_data;
                tx_cnt_d = 4'h0;
                tx_pin_d = 1'b0;
            end
        end else if (tick) begin
            if (tx_cnt_q == uart_link_pkg::TICK_LAST) begin
                tx_cnt_d = 4'h0;
                unique case (tx_st_q)
                    uart_link_pkg::TX_START: begin
                        tx_st_d = uart_link_pkg::TX_DATA;
                        tx_bit_d = 3'h0;
                        tx_pin_d = tx_sh_q[0];
                        tx_sh_d = {1'b0, tx_sh_q[7:1]};
                    end
                    uart_link_pkg::TX_DATA: begin
                        if (tx_bit_q == uart_link_pkg::LAST_BIT) begin
                            tx_st_d = uart_link_pkg::TX_STOP;
                            tx_pin_d = 1'b1;
                        end else begin
                            tx_bit_d = tx_bit_q + 3'h1;
                            tx_pin_d = tx_sh_q[0];
                            tx_sh_d = {1'b0, tx_sh_q[7:1]};
                        end
                    end
                    uart_link_pkg::TX_STOP, uart_link_pkg::TX_IDLE: begin
                        tx_st_d = uart_link_pkg::TX_IDLE;
                    end
                endcase
            end else begin
                tx_cnt_d = tx_cnt_q + 4'h1;
            end
        end
        // clear-to-send checked between characters; three-wire never waits
        tx_ready_d = (tx_st_d == uart_link_pkg::TX_IDLE) && !hib_d && (three_wire || !cts_s_q);
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_st_q <= uart_link_pkg::TX_IDLE;
            tx_cnt_q <= 4'h0;
            tx_bit_q <= 3'h0;
            tx_sh_q <= uart_link_pkg::BYTE_RESET;
            tx_pin_q <= 1'b1;
            tx_ready_q <= 1'b0;
        end else if (ce) begin
            tx_st_q <= tx_st_d;
            tx_cnt_q <= tx_cnt_d;
            tx_bit_q <= tx_bit_d;
            tx_sh_q <= tx_sh_d;
            tx_pin_q <= tx_pin_d;
            tx_ready_q <= tx_ready_d;
        end
    end
    logic attn_q, attn_d, hib_q;
    always_comb begin
        attn_d = attention_req && five_wire && !hib_d;
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            attn_q <= 1'b0;
            hib_q <= 1'b0;
        end else if (ce) begin
            attn_q <= attn_d;
            hib_q <= hib_d;
        end
    end
    assign tx_pin = tx_pin_q;
    assign rts_n = rts_n_q;
    assign attention_to_host = attn_q;
    assign hibernate = hib_q;
    assign tx_ready = tx_ready_q;
    assign rx_data = rx_data_q;
    assign rx_valid = rx_valid_q;
    assign frame_err = frame_err_q;
    assign overrun = overrun_q;
    property p_tx_start_low;
        @(posedge clk) disable iff (rst)
            (ce && tx_st_q == uart_link_pkg::TX_IDLE && tx_valid && tx_ready_q && !hib_d) |=> !tx_pin_q;
    endproperty
    a_tx_start_low: assert property (p_tx_start_low) else $error("start bit not driven low");
    property p_stop_high;
        @(posedge clk) disable iff (rst) (tx_st_q == uart_link_pkg::TX_STOP) |-> tx_pin_q;
    endproperty
    a_stop_high: assert property (p_stop_high) else $error("stop bit not high");
    property p_lsb_first;
        @(posedge clk) disable iff (rst)
            (ce && !hib_d && tick && tx_st_q == uart_link_pkg::TX_START && tx_cnt_q == uart_link_pkg::TICK_LAST)
            |=> tx_pin_q == $past(tx_sh_q[0]);
    endproperty
    a_lsb_first: assert property (p_lsb_first) else $error("first data bit is not the lsb");
    property p_cts_block;
        @(posedge clk) disable iff (rst) (ce && cts_s_q && !three_wire) |=> !tx_ready_q;
    endproperty
    a_cts_block: assert property (p_cts_block) else $error("ready while host withholds permission");
    property p_rts_full;
        @(posedge clk) disable iff (rst) rx_valid_q |-> rts_n_q;
    endproperty
    a_rts_full: assert property (p_rts_full) else $error("host allowed to send into a full holding register");
    property p_three_wire_send;
        @(posedge clk) disable iff (rst)
            (ce && three_wire && !hib_d && tx_st_q == uart_link_pkg::TX_IDLE && tx_valid && tx_ready_q)
            ##1 (ce && three_wire && !hib_d) [*2] |-> tx_st_q != uart_link_pkg::TX_IDLE;
    endproperty
    a_three_wire_send: assert property (p_three_wire_send) else $error("three-wire transmit did not start");
    property p_attention;
        @(posedge clk) disable iff (rst) (ce && attention_req && five_wire && !hib_d) |=> attn_q;
    endproperty
    a_attention: assert property (p_attention) else $error("attention not raised on request");
    property p_attention_cause;
        @(posedge clk) disable iff (rst) $rose(attn_q) |-> $past(attention_req) && !hib_q;
    endproperty
    a_attention_cause: assert property (p_attention_cause) else $error("attention raised without request");
    property p_frame_err;
        @(posedge clk) disable iff (rst)
            $rose(frame_err_q) |-> $past(rx_st_q) == uart_link_pkg::RX_STOP && !$past(rx_s_q);
    endproperty
    a_frame_err: assert property (p_frame_err) else $error("framing error without a low stop sample");
    property p_hib_quiet;
        @(posedge clk) disable iff (rst) (ce && hib_d) |=> tx_pin_q && !attn_q && !tx_ready_q && hib_q;
    endproperty
    a_hib_quiet: assert property (p_hib_quiet) else $error("link active while hibernating");
endmodule

// *** hw/rate_tick.sv ***
`timescale 1ns/1ps
module rate_tick (
    input wire logic clk,             // system clock
    input wire logic rst,             // synchronous reset, active high
    input wire logic ce,              // clock enable
    input wire logic rate_load,       // pulse: apply rate_div
    input wire logic [15:0] rate_div, // requested cycles per oversample tick
    output logic [15:0] divisor,      // divisor in use
    output logic tick                 // one-cycle oversample tick
);
    logic [15:0] div_q, div_d;
    logic [15:0] cnt_q, cnt_d;
    logic tick_q, tick_d;

    always_comb begin
        div_d = div_q;
        cnt_d = cnt_q;
        tick_d = 1'b0;
        if (rate_load) begin
            // divisor below the floor would exceed the maximum rate
            div_d = (rate_div < uart_link_pkg::DIV_MIN) ? uart_link_pkg::DIV_MIN : rate_div;
            cnt_d = div_d - 16'h0001;
        end else if (cnt_q == 16'h0000) begin
            cnt_d = div_q - 16'h0001;
            tick_d = 1'b1;
        end else begin
            cnt_d = cnt_q - 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            div_q <= uart_link_pkg::DIV_DEFAULT;
            cnt_q <= uart_link_pkg::DIV_DEFAULT - 16'h0001;
            tick_q <= 1'b0;
        end else if (ce) begin
            div_q <= div_d;
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign divisor = div_q;
    assign tick = tick_q;

    property p_div_floor;
        @(posedge clk) disable iff (rst) div_q >= uart_link_pkg::DIV_MIN;
    endproperty
    a_div_floor: assert property (p_div_floor) else $error("divisor below rate floor");

    property p_default_rate;
        @(posedge clk) rst |=> div_q == uart_link_pkg::DIV_DEFAULT;
    endproperty
    a_default_rate: assert property (p_default_rate) else $error("default rate not set by reset");
endmodule

// *** include/uart_link_pkg.sv ***
package uart_link_pkg;
    // clock and line rates
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned DEFAULT_BAUD = 115_200;
    localparam int unsigned MAX_BAUD = 3_000_000;
    localparam int unsigned OVERSAMPLE = 16;

    // divisor = clock cycles per oversample tick, nearest whole value
    localparam logic [15:0] DIV_DEFAULT =
        16'((CLK_HZ + (DEFAULT_BAUD * OVERSAMPLE) / 2) / (DEFAULT_BAUD * OVERSAMPLE));
    // smallest divisor that keeps the rate at or below the maximum
    localparam logic [15:0] DIV_MIN =
        16'((CLK_HZ + MAX_BAUD * OVERSAMPLE - 1) / (MAX_BAUD * OVERSAMPLE));

    // character framing: 8 data bits, no parity, 1 stop bit
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [3:0] TICK_MID = 4'h7;
    localparam logic [3:0] TICK_LAST = 4'hF;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    typedef enum logic [1:0] {
        TOPO_FIVE = 2'b00,
        TOPO_FOUR = 2'b01,
        TOPO_THREE = 2'b10
    } topo_e;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_START = 2'b01,
        TX_DATA = 2'b10,
        TX_STOP = 2'b11
    } tx_state_e;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10,
        RX_STOP = 2'b11
    } rx_state_e;
endpackage
